// ---- verilog/vspd_map.svh ----
// constants, timing counts and summary of operation for the set-point block
// Summary of operation
// R01 - armed notify emits v when speed reached
// R02 - notify only in either answer mode
// R03 - cancel drops a pending unfired notify
// R04 - full-scale input maps to maximum speed
// R05 - maximum speed clamps all but voltage mode (analog and pwm set-points stay clamped in voltage mode too)
// R06 - start voltage gives minimum velocity
// R07 - dead band below start voltage stops drive
// R08 - left/right choose sign of positive set-point
// R09 - fault pin as direction: low left, high right
// R10 - direction pin overrides left/right setting
// R11 - pwm above half cw, half stop, below ccw
// R12 - source chooses voltage or pwm set-point
// R13 - pwm uses same limits and direction
// R14 - range limits stop drive unless switched off
// R15 - edge inputs edge-detected, others level-sampled
// R16 - react to input changes within 500 us
// R17 - hall zero crossing or fault pin index
// R18 - fault pin limit only with reference input stored
// R19 - start homing in any operating mode
// R20 - hall homing unavailable on brushed variant
// R21 - encoder homing zeroes at fault pin index
// R22 - power-on homing starts only when set
// R23 - host defines homing switch before start
// R24 - velocity command sets signed target
// R25 - notify fires once per arming
`ifndef VSPD_MAP_SVH
`define VSPD_MAP_SVH
`define VSPD_CLK_MHZ 100
`define VSPD_SAMPLE_US 500
`define VSPD_SAMPLE_CYC (`VSPD_SAMPLE_US * `VSPD_CLK_MHZ)
`define VSPD_FULL_MV 16'h2710
`define VSPD_PWM_HALF 16'h8000
`define VSPD_CHAR_V 8'h76
`define VSPD_CHAR_HOME 8'h68
`define VSPD_HOME_SPEED 16'h0064
`endif

// ---- verilog/vspd_pkg.sv ----
// types shared by the set-point block
package vspd_pkg;
  typedef enum logic [4:0] {
    VSPD_IDLE = 5'b00001,
    VSPD_SEEK = 5'b00010,
    VSPD_HALL = 5'b00100,
    VSPD_ENC = 5'b01000,
    VSPD_DONE = 5'b10000
  } vspd_home_t;
  typedef enum logic [1:0] {
    VSPD_SRC_HOST = 2'h0,
    VSPD_SRC_VOLT = 2'h1,
    VSPD_SRC_PWM = 2'h2
  } vspd_src_t;
endpackage

// ---- verilog/vspd_scale_if.sv ----
// scaling request and result between top and scaler
`timescale 1ns/10ps
interface vspd_scale_if;
  logic signed [16:0] mag_mv;
  logic [15:0] max_speed;
  logic [15:0] min_vel;
  logic [15:0] start_mv;
  logic [15:0] speed;
  modport top (output mag_mv, max_speed, min_vel, start_mv, input speed);
  modport scl (input mag_mv, max_speed, min_vel, start_mv, output speed);
endinterface

// ---- verilog/vspd_scale.sv ----
// magnitude to speed scaler with dead band and minimum velocity
`timescale 1ns/10ps
`include "vspd_map.svh"
module vspd_scale
  import vspd_pkg::*;
(
  vspd_scale_if.scl s
);
  wire [15:0] mag = s.mag_mv[16] ? 16'h0000 : s.mag_mv[15:0];
  wire [15:0] span = `VSPD_FULL_MV - s.start_mv;
  wire [15:0] above = mag - s.start_mv;
  wire [15:0] vspan = (s.max_speed > s.min_vel) ?
                      16'(s.max_speed - s.min_vel) : 16'h0000;
  wire [31:0] prod = 32'(above) * 32'(vspan);
  wire [31:0] quot = (span == 16'h0000) ? 32'h0 : prod / 32'(span);
  wire [31:0] lin = 32'(s.min_vel) + quot;
  wire [15:0] lim = (lin > 32'(s.max_speed)) ? s.max_speed : lin[15:0];
  // dead band and full-scale clamp; linear ramp from minimum to maximum
  assign s.speed = (mag < s.start_mv) ? 16'h0000 : // R07
                   (mag >= `VSPD_FULL_MV) ? s.max_speed : // R04
                   lim; // R06
endmodule

// ---- verilog/vspd_top.sv ----
// set-point decode, velocity notify, reference inputs and homing
`timescale 1ns/10ps
`include "vspd_map.svh"
module vspd_top
  import vspd_pkg::*;
#(
  parameter int SAMPLE_CYC = `VSPD_SAMPLE_CYC,
  parameter bit BRUSHLESS = 1'b1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_setpoint_src,
  input wire logic i_normal_control_mode,
  input wire logic i_voltage_output_mode,
  input wire logic signed [15:0] i_analog_mv,
  input wire logic i_analog_set_input,
  input wire logic [15:0] i_maximum_speed,
  input wire logic [15:0] i_minimum_velocity,
  input wire logic [15:0] i_start_voltage_threshold,
  input wire logic i_positive_turns_left,
  input wire logic i_fault_pin_as_direction_input,
  input wire logic i_fault_pin,
  input wire logic i_velocity_cmd,
  input wire logic signed [15:0] i_velocity_target,
  input wire logic signed [15:0] i_actual_speed,
  input wire logic i_notify_speed_reached,
  input wire logic signed [15:0] i_notify_speed,
  input wire logic i_cancel_speed_notify,
  input wire logic i_answer_mode_one,
  input wire logic i_answer_mode_two,
  input wire logic i_tx_ready,
  input wire logic i_range_limits_off,
  input wire logic signed [31:0] i_actual_pos,
  input wire logic signed [31:0] i_range_limit_value,
  input wire logic signed [31:0] i_range_limit_low,
  input wire logic i_fault_pin_as_reference_input,
  input wire logic i_store_settings_persistently,
  input wire logic [2:0] i_level_inputs,
  input wire logic i_hall_zero,
  input wire logic i_start_homing_sequence,
  input wire logic i_home_to_hall_zero,
  input wire logic i_home_to_encoder_index,
  input wire logic i_homing_at_power_on,
  input wire logic i_homing_defined,
  input wire logic i_homing_switch_hit,
  output logic signed [15:0] o_target_speed,
  output logic o_tx_valid,
  output logic [7:0] o_tx_char,
  output logic o_range_stop,
  output logic o_index_pulse,
  output logic [2:0] o_level_sampled,
  output logic o_fault_edge,
  output logic o_analog_edge,
  output logic o_clear_position,
  output logic o_homing_active,
  output logic signed [15:0] o_homing_speed
);
  // ==========================================================
  // set-point source and direction
  vspd_scale_if sif ();
  vspd_scale u_scale (.s(sif));
  logic [15:0] pwm_acc_q, pwm_acc_d, pwm_cnt_q;
  logic [15:0] duty_q;
  logic ana_q, flt_q, hall_q;
  logic [15:0] smp_q;
  logic ref_q;
  wire pwm_sel = (i_setpoint_src == 2'(VSPD_SRC_PWM));
  wire volt_sel = (i_setpoint_src == 2'(VSPD_SRC_VOLT));
  wire ext_src = i_normal_control_mode & (pwm_sel | volt_sel); // R12
  // pwm duty maps onto +-full scale so all limits apply alike
  // worked in 32 bits: the product of duty offset and full scale needs them
  wire signed [31:0] duty_full =
    ($signed({16'h0000, duty_q}) - $signed(32'(`VSPD_PWM_HALF))) *
    $signed(32'(`VSPD_FULL_MV)) / $signed(32'(`VSPD_PWM_HALF)); // R11 R13
  wire signed [16:0] duty_mv = 17'(duty_full);
  wire signed [16:0] in_mv = pwm_sel ? duty_mv : 17'(i_analog_mv);
  wire neg_in = in_mv < 0;
  assign sif.mag_mv = neg_in ? -in_mv : in_mv;
  assign sif.max_speed = i_maximum_speed;
  assign sif.min_vel = i_minimum_velocity;
  assign sif.start_mv = i_start_voltage_threshold;
  // pin direction wins over the stored left/right choice
  wire left = i_fault_pin_as_direction_input ?
              ~i_fault_pin : i_positive_turns_left; // R09 R10
  wire rev = neg_in ^ left; // R08
  wire signed [15:0] ext_spd = rev ? -$signed(sif.speed) : $signed(sif.speed);
  wire [15:0] tmag = i_velocity_target[15] ?
                     16'(-i_velocity_target) : i_velocity_target;
  wire [15:0] tlim = (!i_voltage_output_mode && tmag > i_maximum_speed) ?
                     i_maximum_speed : tmag; // R05
  wire signed [15:0] host_spd = i_velocity_target[15] ?
                     -$signed(tlim) : $signed(tlim); // R24
  logic signed [15:0] host_q;
  wire over_hi = i_actual_pos >= i_range_limit_value;
  wire over_lo = i_actual_pos <= i_range_limit_low;
  wire signed [15:0] raw_spd = ext_src ? ext_spd : host_q;
  wire range_stop = !i_range_limits_off &&
    ((over_hi && raw_spd > 0) || (over_lo && raw_spd < 0)); // R14
  // ==========================================================
  // homing sequencer
  vspd_home_t st_q, st_d;
  logic po_done_q;
  wire flt_edge = i_fault_pin & ~flt_q; // R15
  wire ana_edge = i_analog_set_input & ~ana_q; // R15
  wire hall_edge = i_hall_zero & ~hall_q; // R17
  wire ref_en = i_fault_pin_as_reference_input & ref_q; // R18
  wire po_start = i_homing_at_power_on & ~po_done_q; // R22
  always_comb begin
    st_d = st_q;
    case (st_q)
      VSPD_IDLE: begin
        // accepted in any mode; the host must define a switch first
        if ((i_start_homing_sequence | po_start) & i_homing_defined) begin
          st_d = VSPD_SEEK; // R19 R23
        end else if (i_home_to_hall_zero & BRUSHLESS) begin
          st_d = VSPD_HALL; // R20
        end else if (i_home_to_encoder_index) begin
          st_d = VSPD_ENC; // R21
        end
      end
      VSPD_SEEK: if (i_homing_switch_hit | (ref_en & flt_edge)) begin
        st_d = VSPD_DONE;
      end
      VSPD_HALL: if (hall_edge) begin
        st_d = VSPD_DONE;
      end
      VSPD_ENC: if (flt_edge) begin
        st_d = VSPD_DONE; // R17
      end
      VSPD_DONE: st_d = VSPD_IDLE;
      default: st_d = VSPD_IDLE;
    endcase
  end
  wire homing = (st_q != VSPD_IDLE) && (st_q != VSPD_DONE);
  // ==========================================================
  // velocity notify
  logic armed_q;
  wire ans_on = i_answer_mode_one | i_answer_mode_two; // R02
  wire reached = (i_notify_speed >= 0) ? (i_actual_speed >= i_notify_speed)
                                       : (i_actual_speed <= i_notify_speed);
  wire fire = armed_q & reached & ans_on & i_tx_ready & ~o_tx_valid; // R01
  // ==========================================================
  // pwm duty measure and level sampling
  wire pwm_rise = i_analog_set_input & ~ana_q;
  // the rising cycle is itself high, so it counts as the first high cycle
  assign pwm_acc_d = pwm_rise ? 16'h0001 :
                     16'(pwm_acc_q + {15'h0000, i_analog_set_input});
  wire smp_tick = (smp_q == 16'(SAMPLE_CYC - 1)); // R16
  wire [31:0] duty_w = (pwm_cnt_q == 16'h0000) ? 32'h0 :
                       (32'(pwm_acc_q) << 16) / 32'(pwm_cnt_q);
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ana_q <= 1'b0;
      flt_q <= 1'b0;
      hall_q <= 1'b0;
      pwm_acc_q <= 16'h0000;
      pwm_cnt_q <= 16'h0000;
      duty_q <= `VSPD_PWM_HALF;
      smp_q <= 16'h0000;
      o_level_sampled <= 3'h0;
    end else begin
      ana_q <= i_analog_set_input;
      flt_q <= i_fault_pin;
      hall_q <= i_hall_zero;
      pwm_acc_q <= pwm_acc_d;
      pwm_cnt_q <= pwm_rise ? 16'h0001 : 16'(pwm_cnt_q + 16'h0001);
      if (pwm_rise) begin
        duty_q <= (duty_w > 32'hFFFF) ? 16'hFFFF : duty_w[15:0];
      end
      smp_q <= smp_tick ? 16'h0000 : 16'(smp_q + 16'h0001);
      if (smp_tick) begin
        o_level_sampled <= i_level_inputs; // R15
      end
    end
  end
  // ==========================================================
  // outputs and control registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_q <= VSPD_IDLE;
      po_done_q <= 1'b0;
      ref_q <= 1'b0;
      armed_q <= 1'b0;
      host_q <= 16'sh0000;
      o_target_speed <= 16'sh0000;
      o_tx_valid <= 1'b0;
      o_tx_char <= 8'h00;
      o_range_stop <= 1'b0;
      o_index_pulse <= 1'b0;
      o_fault_edge <= 1'b0;
      o_analog_edge <= 1'b0;
      o_clear_position <= 1'b0;
      o_homing_active <= 1'b0;
      o_homing_speed <= 16'sh0000;
    end else begin
      st_q <= st_d;
      po_done_q <= 1'b1;
      if (i_store_settings_persistently) begin
        ref_q <= i_fault_pin_as_reference_input; // R18
      end
      if (i_velocity_cmd) begin
        host_q <= host_spd; // R24
      end
      // arm wins over cancel only when both arrive together
      if (i_notify_speed_reached) begin
        armed_q <= 1'b1;
      end else if (i_cancel_speed_notify | fire) begin
        armed_q <= 1'b0; // R03 R25
      end
      o_tx_valid <= fire;
      if (fire) begin
        o_tx_char <= `VSPD_CHAR_V; // R01
      end
      o_range_stop <= range_stop;
      o_target_speed <= (range_stop | homing) ? 16'sh0000 : raw_spd;
      o_index_pulse <= BRUSHLESS ? hall_edge : (ref_en & flt_edge); // R17
      o_fault_edge <= flt_edge;
      o_analog_edge <= ana_edge;
      o_clear_position <= (st_q != VSPD_DONE) && (st_d == VSPD_DONE);
      o_homing_active <= homing;
      o_homing_speed <= homing ? $signed(`VSPD_HOME_SPEED) : 16'sh0000;
    end
  end
endmodule

// ---- tb/vspd_top_chk.sv ----
// port assertions for the set-point block
`timescale 1ns/10ps
module vspd_top_chk
  import vspd_pkg::*;
#(
  parameter int SAMPLE_CYC = 50,
  parameter bit BRUSHLESS = 1'h1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_setpoint_src,
  input wire logic signed [15:0] i_analog_mv,
  input wire logic [15:0] i_maximum_speed,
  input wire logic [15:0] i_start_voltage_threshold,
  input wire logic i_answer_mode_one,
  input wire logic i_answer_mode_two,
  input wire logic i_range_limits_off,
  input wire logic i_start_homing_sequence,
  input wire logic i_homing_defined,
  input wire logic signed [15:0] o_target_speed,
  input wire logic o_tx_valid,
  input wire logic o_range_stop,
  input wire logic o_clear_position,
  input wire logic o_homing_active,
  input wire logic signed [15:0] o_homing_speed
);
  // ==========================================================
  // helpers
  wire logic signed [16:0] thr = {1'h0, i_start_voltage_threshold};
  wire logic signed [16:0] lim = {1'h0, i_maximum_speed};
  wire logic in_band = i_analog_mv < thr && i_analog_mv > -thr;
  wire logic in_lim = o_target_speed <= lim && o_target_speed >= -lim;
  wire logic volt = i_setpoint_src == 2'h1;
  wire logic ans = i_answer_mode_one | i_answer_mode_two;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================================
  // properties; settle windows of four cycles cover scaler latency
  property p_clamp; (volt && $stable(i_analog_mv))[*4] |-> in_lim; endproperty
  a_clamp: assert property (p_clamp) else $error("speed over max");
  property p_dead;
    (volt && in_band)[*4] |-> o_target_speed == 16'h0000;
  endproperty
  a_dead: assert property (p_dead) else $error("moving in dead band");
  property p_ans; o_tx_valid |-> $past(ans); endproperty
  a_ans: assert property (p_ans) else $error("notify without mode");
  property p_once; o_tx_valid |=> !o_tx_valid; endproperty
  a_once: assert property (p_once) else $error("notify repeated");
  property p_noff; i_range_limits_off |=> !o_range_stop; endproperty
  a_noff: assert property (p_noff) else $error("stop with limits off");
  property p_href;
    i_start_homing_sequence && !i_homing_defined && !o_homing_active
      |=> !o_homing_active;
  endproperty
  a_href: assert property (p_href) else $error("homing undefined");
  property p_hspd; o_homing_active |-> o_homing_speed == 16'h0064; endproperty
  a_hspd: assert property (p_hspd) else $error("homing speed");
  property p_clr; o_clear_position |=> !o_clear_position; endproperty
  a_clr: assert property (p_clr) else $error("clear too long");
  c_fire: cover property (o_tx_valid);
  c_home: cover property (o_clear_position);
  c_stop: cover property (o_range_stop);
endmodule
bind vspd_top vspd_top_chk #(.SAMPLE_CYC(SAMPLE_CYC), .BRUSHLESS(BRUSHLESS))
  chk_u (.*);

// ---- tb/vspd_host.sv ----
// host model: takes notification characters, may stall
`timescale 1ns/10ps
module vspd_host (
  input wire logic i_sys_clk,
  input wire logic i_slow,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_char,
  output logic o_tx_ready,
  output logic [7:0] o_v_count
);
  logic [2:0] busy_q = 3'h0;
  logic [7:0] cnt_q = 8'h00;
  assign o_v_count = cnt_q;
  assign o_tx_ready = busy_q == 3'h0;
  // a slow host stays busy a few cycles after each character
  always @(posedge i_sys_clk) begin
    if (i_tx_valid && i_tx_char == 8'h76) cnt_q <= cnt_q + 8'h01;
    if (i_tx_valid && i_slow) busy_q <= 3'h4;
    else if (busy_q != 3'h0) busy_q <= busy_q - 3'h1;
  end
endmodule

// ---- tb/vspd_top_tb.sv ----
// self-checking bench for the set-point block
`timescale 1ns/10ps
module vspd_top_tb;
  import vspd_pkg::*;
  localparam int SC = 50;
  logic i_sys_clk = '0, i_rst_n = '0, i_normal_control_mode = '1;
  logic i_voltage_output_mode = '0, i_analog_set_input = '0, slow = '1;
  logic i_positive_turns_left = '0, i_fault_pin_as_direction_input = '0;
  logic i_fault_pin = '0, i_velocity_cmd = '0, i_notify_speed_reached = '0;
  logic i_cancel_speed_notify = '0, i_answer_mode_one = '0;
  logic i_answer_mode_two = '0, i_tx_ready, i_range_limits_off = '0;
  logic i_fault_pin_as_reference_input = '0, i_hall_zero = '0;
  logic i_store_settings_persistently = '0, i_start_homing_sequence = '0;
  logic i_home_to_hall_zero = '0, i_home_to_encoder_index = '0;
  logic i_homing_at_power_on = '0, i_homing_defined = '0;
  logic i_homing_switch_hit = '0;
  logic [1:0] i_setpoint_src = '0;
  logic [2:0] i_level_inputs = '0, o_level_sampled;
  logic [15:0] i_maximum_speed = 16'h1388, i_minimum_velocity = 16'h000A;
  logic [15:0] i_start_voltage_threshold = 16'h0064;
  logic signed [15:0] i_analog_mv = '0, i_velocity_target = '0;
  logic signed [15:0] i_actual_speed = '0, i_notify_speed = '0;
  logic signed [31:0] i_actual_pos = '0, i_range_limit_value = 32'h00001000;
  logic signed [31:0] i_range_limit_low = 32'hFFFFF000;
  logic signed [15:0] o_target_speed, o_homing_speed;
  logic o_tx_valid, o_range_stop, o_index_pulse, o_fault_edge;
  logic o_analog_edge, o_clear_position, o_homing_active;
  logic [7:0] o_tx_char, v_count;
  int errors = 0, compares = 0;
  vspd_top #(.SAMPLE_CYC(SC)) dut_u (.*);
  vspd_host host_u (.i_sys_clk(i_sys_clk), .i_slow(slow),
    .i_tx_valid(o_tx_valid), .i_tx_char(o_tx_char),
    .o_tx_ready(i_tx_ready), .o_v_count(v_count));
  initial forever #5 i_sys_clk = ~i_sys_clk;
  // ==========================================================
  // shared tasks; every wait is bounded so a hang ends the run
  task automatic summarize();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic pulse(ref logic s);
    s = '1;
    cyc(1);
    s = '0;
  endtask
  task automatic speed_is(logic [15:0] exp);
    int k;
    for (k = 0; k < 20 && o_target_speed !== exp; k++) cyc(1);
    chk("target speed", o_target_speed, exp);
    if (k == 20) summarize();
  endtask
  task automatic flag_is(string n, ref logic f, input logic exp);
    int k;
    for (k = 0; k < 20 && f !== exp; k++) cyc(1);
    chk(n, {15'h0000, f}, {15'h0000, exp});
    if (k == 20) summarize();
  endtask
  // ==========================================================
  // scenarios
  task automatic t_analog();
    i_setpoint_src = 2'h1;
    i_analog_mv = 16'h2710;
    speed_is(16'h1388);
    i_analog_mv = 16'h0064;
    speed_is(16'h000A);
    i_analog_mv = 16'hFFCF;
    speed_is(16'h0000);
    cyc(4);
    i_analog_mv = 16'h2710;
    i_positive_turns_left = '1;
    speed_is(16'hEC78);
    i_positive_turns_left = '0;
    i_fault_pin_as_direction_input = '1;
    speed_is(16'hEC78);
    i_fault_pin = '1;
    speed_is(16'h1388);
    i_fault_pin_as_direction_input = '0;
  endtask
  task automatic pwm_run(int hi);
    repeat (3) begin
      i_analog_set_input = '1;
      flag_is("analog edge", o_analog_edge, '1);
      cyc(hi - 1);
      i_analog_set_input = '0;
      cyc(20 - hi);
    end
  endtask
  task automatic t_pwm();
    i_setpoint_src = 2'h2;
    pwm_run(15);
    speed_is(16'h09AF);
    pwm_run(5);
    speed_is(16'hF651);
    pwm_run(10);
    speed_is(16'h0000);
  endtask
  task automatic t_host();
    i_setpoint_src = 2'h0;
    i_velocity_target = 16'h1770;
    pulse(i_velocity_cmd);
    speed_is(16'h1388);
    i_voltage_output_mode = '1;
    pulse(i_velocity_cmd);
    speed_is(16'h1770);
    i_voltage_output_mode = '0;
    i_velocity_target = 16'hFF9C;
    pulse(i_velocity_cmd);
    speed_is(16'hFF9C);
    i_actual_pos = 32'hFFFFE000;
    flag_is("range stop", o_range_stop, '1);
    i_range_limits_off = '1;
    flag_is("range stop", o_range_stop, '0);
  endtask
  task automatic t_notify();
    i_answer_mode_two = '1;
    i_notify_speed = 16'h03E8;
    pulse(i_notify_speed_reached);
    i_actual_speed = 16'h04B0;
    flag_is("tx valid", o_tx_valid, '1);
    chk("tx char", {8'h00, o_tx_char}, 16'h0076);
    cyc(10);
    chk("notify count", {8'h00, v_count}, 16'h0001);
    i_actual_speed = '0;
    pulse(i_notify_speed_reached);
    pulse(i_cancel_speed_notify);
    i_actual_speed = 16'h04B0;
    cyc(10);
    chk("notify count", {8'h00, v_count}, 16'h0001);
    i_actual_speed = '0;
    i_answer_mode_two = '0;
    pulse(i_notify_speed_reached);
    i_actual_speed = 16'h04B0;
    cyc(10);
    chk("notify count", {8'h00, v_count}, 16'h0001);
  endtask
  task automatic t_homing();
    int k;
    pulse(i_start_homing_sequence);
    cyc(2);
    chk("homing", {15'h0000, o_homing_active}, 16'h0000);
    i_homing_defined = '1;
    pulse(i_start_homing_sequence);
    flag_is("homing", o_homing_active, '1);
    chk("homing speed", o_homing_speed, 16'h0064);
    pulse(i_homing_switch_hit);
    flag_is("clear position", o_clear_position, '1);
    flag_is("homing", o_homing_active, '0);
    pulse(i_home_to_hall_zero);
    flag_is("homing", o_homing_active, '1);
    pulse(i_hall_zero);
    flag_is("clear position", o_clear_position, '1);
    flag_is("index pulse", o_index_pulse, '1);
    flag_is("homing", o_homing_active, '0);
    i_fault_pin = '0;
    cyc(2);
    pulse(i_home_to_encoder_index);
    flag_is("homing", o_homing_active, '1);
    pulse(i_fault_pin);
    flag_is("clear position", o_clear_position, '1);
    flag_is("fault edge", o_fault_edge, '1);
    flag_is("homing", o_homing_active, '0);
    // levels held well past the sampling period
    i_level_inputs = 3'h5;
    for (k = 0; k < 2 * SC && o_level_sampled !== 3'h5; k++) cyc(1);
    chk("levels", {13'h0000, o_level_sampled}, 16'h0005);
  endtask
  initial begin
    cyc(8);
    i_rst_n = '1;
    cyc(2);
    chk("homing", {15'h0000, o_homing_active}, 16'h0000);
    t_analog();
    t_pwm();
    t_host();
    t_notify();
    t_homing();
    summarize();
  end
endmodule
